// >>> logic/decoder_error_detection.sv
// Two-byte line decoder error checking and illegal character classification
//
// Summary of operation
// - Each byte decoder has its own checker
// - Violation flag alone does not classify errors
// - Checker flags long runs and disparity faults
// - Flag set in check state; done strobes
// - Classifier uses control and violation, both bytes
// - Classifier separates special characters from errors
// - Illegal flag only for genuine error characters
// - Classifier: idle, detect on start, then done
// - Disparity value 1 means negative
// - Bit order reversed within each byte
// - Word valid in, word done when flags valid
// - Wait for decode and checkers before done
`timescale 1ns/1ps
`default_nettype none
`include "decoder_error_detection_defs.svh"

module decoder_error_detection
	import decoder_error_detection_pkg::*;
(
	input  wire logic        core_clk,         // Decoder clock, 250 MHz
	input  wire logic        rst_n,            // Synchronous reset, active low
	// Word stream from the protocol controller
	input  wire logic        word_valid,       // Encoded word is stable
	input  wire logic [19:0] encoded_word,     // Upper group 19:10, lower 9:0
	output logic             word_done,        // Decode and flags complete
	output logic             illegal_char_flag,// Genuine illegal character
	// Handshake with the decode function
	output logic             decode_start,     // One-cycle start to decode function
	input  wire logic        decode_done,      // Decode function finished
	input  wire logic        control_char_indication_upper, // Upper is special
	input  wire logic        control_char_indication_lower, // Lower is special
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Interrupt
	output logic             irq
);

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	main_state_t main_state_reg;           // Main decode control state
	cls_state_t  cls_state_reg;            // Classifier state
	logic [9:0]  upper_group_reg;          // Upper group in coded order
	logic [9:0]  lower_group_reg;          // Lower group in coded order
	logic        chk_start_reg;            // Start strobe to the lower checker; the upper gets it one cycle later
	logic        upper_viol;               // Upper checker violation
	logic        lower_viol;               // Lower checker violation
	logic        upper_rd_out;             // Disparity after upper group
	logic        lower_rd_out;             // Disparity after lower group
	logic        upper_done;               // Upper checker strobe
	logic        lower_done;               // Lower checker strobe
	logic        upper_seen_reg;           // Upper checker has finished
	logic        lower_seen_reg;           // Lower checker has finished
	logic        dec_seen_reg;             // Decode function has finished
	logic        k_upper_reg;              // Captured control indication, upper
	logic        k_lower_reg;              // Captured control indication, lower
	logic        cls_start_reg;            // Classify start strobe
	logic        cls_done_reg;             // Classifier finished strobe
	logic [1:0]  ctrl_reg;                 // Disparity in and auto update
	logic [2:0]  irq_status_reg;           // Sticky events
	logic [2:0]  irq_enable_reg;           // Interrupt enables
	logic [15:0] word_count_reg;           // Words checked
	logic [15:0] ill_count_reg;            // Illegal characters reported
	logic        ill_next;                 // Classification result
	logic        setup_phase;              // APB setup cycle
	logic        access_done;              // APB access completes this edge
	logic        wr_en;                    // Register write this edge
	logic        addr_ok;                  // Address is mapped
	logic [31:0] rd_value;                 // Read mux output
	logic [2:0]  irq_set;                  // Events this cycle
	logic [2:0]  irq_clr;                  // Software clear this cycle

	// ------------------------------------------------------------------
	// Per-byte checkers
	// ------------------------------------------------------------------
	// Lower group checked with the programmed disparity, upper follows it
	per_byte_check_unit lower_check (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.start         (chk_start_reg),
		.code_group    (lower_group_reg),
		.rd_in         (ctrl_reg[`DED_CTRL_DISP_BIT]),
		.violation_reg (lower_viol),
		.rd_out_reg    (lower_rd_out),
		.done_reg      (lower_done)
	);

	// Upper group start is delayed one cycle so its disparity input is settled
	logic upper_start_reg;                 // Start for upper checker

	per_byte_check_unit upper_check (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.start         (upper_start_reg),
		.code_group    (upper_group_reg),
		.rd_in         (lower_rd_out),
		.violation_reg (upper_viol),
		.rd_out_reg    (upper_rd_out),
		.done_reg      (upper_done)
	);

	// ------------------------------------------------------------------
	// Main decode control
	// ------------------------------------------------------------------
	// Word taken only in idle; a new word clears the previous result
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			main_state_reg  <= MAIN_IDLE;
			upper_group_reg <= 10'h000;
			lower_group_reg <= 10'h000;
			chk_start_reg   <= 1'b0;
			upper_start_reg <= 1'b0;
			decode_start    <= 1'b0;
			cls_start_reg   <= 1'b0;
			word_done       <= 1'b0;
		end else begin
			chk_start_reg   <= 1'b0;
			decode_start    <= 1'b0;
			cls_start_reg   <= 1'b0;
			upper_start_reg <= chk_start_reg;
			unique case (main_state_reg)
				MAIN_IDLE: begin
					if (word_valid) begin
						main_state_reg <= MAIN_ASSIGN;
						word_done      <= 1'b0;
					end
				end
				MAIN_ASSIGN: begin
					// Label bit 0 sits in coded position a, the group MSB
					for (int i = 0; i < 10; i++) begin
						lower_group_reg[i] <= encoded_word[9 - i];
						upper_group_reg[i] <= encoded_word[19 - i];
					end
					chk_start_reg  <= 1'b1;
					decode_start   <= 1'b1;
					main_state_reg <= MAIN_WAIT;
				end
				MAIN_WAIT: begin
					// All three must report, in any order
					if (dec_seen_reg && upper_seen_reg && lower_seen_reg) begin
						main_state_reg <= MAIN_DONE;
					end
				end
				MAIN_DONE: begin
					cls_start_reg  <= 1'b1;
					main_state_reg <= MAIN_FINISH;
				end
				MAIN_FINISH: begin
					// Word done waits for the classifier so the flag is valid
					if (cls_done_reg) begin
						word_done      <= 1'b1;
						main_state_reg <= MAIN_IDLE;
					end
				end
				default: begin
					main_state_reg <= MAIN_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Completion tracking
	// ------------------------------------------------------------------
	// Strobes may arrive in different cycles; remember each until the next word is assigned
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			upper_seen_reg <= 1'b0;
			lower_seen_reg <= 1'b0;
			dec_seen_reg   <= 1'b0;
			k_upper_reg    <= 1'b0;
			k_lower_reg    <= 1'b0;
		end else if (main_state_reg == MAIN_ASSIGN) begin
			upper_seen_reg <= 1'b0;
			lower_seen_reg <= 1'b0;
			dec_seen_reg   <= 1'b0;
		end else begin
			if (upper_done) begin
				upper_seen_reg <= 1'b1;
			end
			if (lower_done) begin
				lower_seen_reg <= 1'b1;
			end
			// Control indications are valid with the decode done strobe
			if (decode_done && main_state_reg == MAIN_WAIT) begin
				dec_seen_reg <= 1'b1;
				k_upper_reg  <= control_char_indication_upper;
				k_lower_reg  <= control_char_indication_lower;
			end
		end
	end

	// ------------------------------------------------------------------
	// Classifier
	// ------------------------------------------------------------------
	// A violating byte is genuine only if it is not a special character
	assign ill_next = (upper_viol & ~k_upper_reg) |
	                  (lower_viol & ~k_lower_reg);

	// Idle, detect, done; the flag holds until the next word arrives
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cls_state_reg     <= CLS_IDLE;
			cls_done_reg      <= 1'b0;
			illegal_char_flag <= 1'b0;
		end else begin
			cls_done_reg <= 1'b0;
			unique case (cls_state_reg)
				CLS_IDLE: begin
					if (cls_start_reg) begin
						cls_state_reg <= CLS_DETECT;
					end else if (main_state_reg == MAIN_IDLE && word_valid) begin
						illegal_char_flag <= 1'b0;
					end
				end
				CLS_DETECT: begin
					illegal_char_flag <= ill_next;
					cls_state_reg     <= CLS_DONE;
				end
				CLS_DONE: begin
					cls_done_reg  <= 1'b1;
					cls_state_reg <= CLS_IDLE;
				end
				default: begin
					cls_state_reg <= CLS_IDLE;
				end
			endcase
		end
	end
	// The block never alters the word on an illegal character; the controller acts.

	// ------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_en       = access_done & pwrite & ~pslverr;

	// Mapped offsets; the clear register is write-only and reads zero
	always_comb begin
		addr_ok  = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (paddr)
			`DED_CTRL_OFFSET:       rd_value = {30'h0000_0000, ctrl_reg};
			`DED_STATUS_OFFSET:     rd_value = {25'h000_0000,
			                          (main_state_reg != MAIN_IDLE),
			                          upper_rd_out, k_lower_reg, k_upper_reg,
			                          lower_viol, upper_viol, illegal_char_flag};
			`DED_IRQ_STATUS_OFFSET: rd_value = {29'h0000_0000, irq_status_reg};
			`DED_IRQ_CLEAR_OFFSET:  rd_value = 32'h0000_0000;
			`DED_IRQ_ENABLE_OFFSET: rd_value = {29'h0000_0000, irq_enable_reg};
			`DED_WORD_COUNT_OFFSET: rd_value = {16'h0000, word_count_reg};
			`DED_ILL_COUNT_OFFSET:  rd_value = {16'h0000, ill_count_reg};
			default:                addr_ok  = 1'b0;
		endcase
	end

	// Answer is registered at the setup edge, so every access has no wait state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (setup_phase) begin
			pready  <= 1'b1;
			pslverr <= ~addr_ok;
			prdata  <= pwrite ? 32'h0000_0000 : rd_value;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	// With auto update on, each word leaves the disparity its upper byte ended with
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl_reg <= `DED_CTRL_RESET;
		end else if (wr_en && paddr == `DED_CTRL_OFFSET) begin
			ctrl_reg <= pwdata[1:0];
		end else if (upper_done && ctrl_reg[`DED_CTRL_AUTO_BIT]) begin
			ctrl_reg[`DED_CTRL_DISP_BIT] <= upper_rd_out;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------------
	assign irq_set = {(upper_done & upper_viol) | (lower_done & lower_viol),
	                  cls_done_reg & illegal_char_flag,
	                  cls_done_reg};
	assign irq_clr = (wr_en && paddr == `DED_IRQ_CLEAR_OFFSET) ? pwdata[2:0] : 3'h0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_status_reg <= 3'h0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
		end
	end

	// Enable register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_enable_reg <= `DED_IRQ_ENABLE_RESET;
		end else if (wr_en && paddr == `DED_IRQ_ENABLE_OFFSET) begin
			irq_enable_reg <= pwdata[2:0];
		end
	end

	// Output registered, so it follows the status by one cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_reg & irq_enable_reg);
		end
	end

	// ------------------------------------------------------------------
	// Statistics
	// ------------------------------------------------------------------
	// Counters wrap silently; software samples them as it needs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			word_count_reg <= 16'h0000;
			ill_count_reg  <= 16'h0000;
		end else if (cls_done_reg) begin
			word_count_reg <= word_count_reg + 16'h0001;
			if (illegal_char_flag) begin
				ill_count_reg <= ill_count_reg + 16'h0001;
			end
		end
	end

endmodule
`default_nettype wire

// >>> logic/decoder_error_detection_defs.svh
// Register offsets, field positions and reset values of the decoder error detection block
`ifndef DECODER_ERROR_DETECTION_DEFS_SVH
`define DECODER_ERROR_DETECTION_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DED_CTRL_OFFSET        8'h00
`define DED_STATUS_OFFSET      8'h04
`define DED_IRQ_STATUS_OFFSET  8'h08
`define DED_IRQ_CLEAR_OFFSET   8'h0C
`define DED_IRQ_ENABLE_OFFSET  8'h10
`define DED_WORD_COUNT_OFFSET  8'h14
`define DED_ILL_COUNT_OFFSET   8'h18

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DED_CTRL_DISP_BIT      0
`define DED_CTRL_AUTO_BIT      1
`define DED_IRQ_DONE_BIT       0
`define DED_IRQ_ILL_BIT        1
`define DED_IRQ_VIOL_BIT       2

// ----------------------------------------------------------------------
// Reset values and code group limits
// ----------------------------------------------------------------------
`define DED_CTRL_RESET         2'h3
`define DED_IRQ_ENABLE_RESET   3'h0
`define DED_MAX_RUN            6

`endif

// >>> logic/decoder_error_detection_pkg.sv
// Types shared by the decoder error detection block
`default_nettype none
package decoder_error_detection_pkg;

	// Per-byte checker states
	typedef enum logic [1:0] {
		CHK_IDLE  = 2'b00,
		CHK_CHECK = 2'b01,
		CHK_DONE  = 2'b10
	} chk_state_t;

	// Main decode control states
	typedef enum logic [2:0] {
		MAIN_IDLE   = 3'b000,
		MAIN_ASSIGN = 3'b001,
		MAIN_WAIT   = 3'b010,
		MAIN_DONE   = 3'b011,
		MAIN_FINISH = 3'b100
	} main_state_t;

	// Classifier states
	typedef enum logic [1:0] {
		CLS_IDLE   = 2'b00,
		CLS_DETECT = 2'b01,
		CLS_DONE   = 2'b10
	} cls_state_t;

endpackage
`default_nettype wire

// >>> logic/per_byte_check_unit.sv
// Per-byte code violation checker for one ten-bit code group
`timescale 1ns/1ps
`default_nettype none
`include "decoder_error_detection_defs.svh"

module per_byte_check_unit
	import decoder_error_detection_pkg::*;
(
	input  wire logic       core_clk,       // Decoder clock
	input  wire logic       rst_n,          // Synchronous reset, active low
	input  wire logic       start,          // One-cycle start strobe
	input  wire logic [9:0] code_group,     // Group in coded order, a in bit 0
	input  wire logic       rd_in,          // 1 = negative running disparity
	output logic            violation_reg,  // Code violation seen
	output logic            rd_out_reg,     // Disparity after this group
	output logic            done_reg        // One-cycle check-complete strobe
);

	chk_state_t state_reg;                  // Checker state
	logic [3:0] ones;                       // Ones in the whole group
	logic [2:0] ones6;                      // Ones in the six-bit sub-block
	logic [2:0] ones4;                      // Ones in the four-bit sub-block
	logic       run_bad;                    // Run of identical bits too long
	logic       disp_bad;                   // Group unbalanced the wrong way

	// ------------------------------------------------------------------
	// Group analysis
	// ------------------------------------------------------------------
	// Balance and run length; only syntax is judged, not meaning
	always_comb begin
		ones  = 4'h0;
		ones6 = 3'h0;
		ones4 = 3'h0;
		run_bad = 1'b0;
		for (int i = 0; i < 10; i++) begin
			ones = ones + {3'h0, code_group[i]};
		end
		for (int i = 0; i < 6; i++) begin
			ones6 = ones6 + {2'h0, code_group[i]};
		end
		for (int i = 6; i < 10; i++) begin
			ones4 = ones4 + {2'h0, code_group[i]};
		end
		// Six identical neighbours is more than the code ever emits
		for (int i = 0; i <= 10 - `DED_MAX_RUN; i++) begin
			if (code_group[i +: `DED_MAX_RUN] == {`DED_MAX_RUN{1'b0}} ||
			    code_group[i +: `DED_MAX_RUN] == {`DED_MAX_RUN{1'b1}}) begin
				run_bad = 1'b1;
			end
		end
		// A positive group needs negative disparity before it, and vice versa
		disp_bad = (ones == 4'h6 && !rd_in) || (ones == 4'h4 && rd_in) ||
		           (ones < 4'h4) || (ones > 4'h6) ||
		           (ones6 < 3'h2) || (ones6 > 3'h4) ||
		           (ones4 < 3'h1) || (ones4 > 3'h3);
	end

	// ------------------------------------------------------------------
	// Checker state machine
	// ------------------------------------------------------------------
	// Flag is set in the check state, strobe raised on entering done
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_reg     <= CHK_IDLE;
			violation_reg <= 1'b0;
			rd_out_reg    <= 1'b1;
			done_reg      <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			unique case (state_reg)
				CHK_IDLE: begin
					if (start) begin
						state_reg <= CHK_CHECK;
					end
				end
				CHK_CHECK: begin
					// Raw flag only; control characters are sorted out later
					violation_reg <= run_bad | disp_bad;
					if (ones == 4'h5) begin
						rd_out_reg <= rd_in;
					end else begin
						rd_out_reg <= (ones < 4'h5);
					end
					state_reg <= CHK_DONE;
					done_reg  <= 1'b1;
				end
				CHK_DONE: begin
					state_reg <= CHK_IDLE;
				end
				default: begin
					state_reg <= CHK_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// >>> tb/decoder_error_detection_sva.sv
// Assertion checker for the decoder error detection block, with its bind
`timescale 1ns/1ps
`default_nettype none
module decoder_error_detection_sva (
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        word_valid,
	input wire logic [19:0] encoded_word,
	input wire logic        word_done,
	input wire logic        illegal_char_flag,
	input wire logic        decode_start,
	input wire logic        decode_done,
	input wire logic        control_char_indication_upper,
	input wire logic        control_char_indication_lower,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        irq
);
	// ----------------------------------------------------------------
	// One clock domain, so clock and reset are given once
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	AST_START_PULSE: assert property (decode_start |=> !decode_start)
		else $error("decode start longer than one cycle");
	AST_START_CLEARS: assert property (decode_start |-> !word_done && !illegal_char_flag)
		else $error("old result still shown after a word was taken");
	AST_NO_EARLY_DONE: assert property (decode_start |=> !word_done [*4])
		else $error("word done before decode and checks could finish");
	AST_DONE_BOUND: assert property (decode_start |-> ##[5:60] word_done)
		else $error("word done did not arrive");
	AST_DONE_HOLD: assert property (word_done && !word_valid |=> word_done)
		else $error("word done dropped without a new word");
	AST_FLAG_HOLD: assert property (word_done && $past(word_done) |-> $stable(illegal_char_flag))
		else $error("illegal flag changed while result held");
	// Zero wait state slave: the first access cycle answers
	AST_PREADY_ACCESS: assert property (psel && !penable ##1 psel && penable |-> pready)
		else $error("pready missing in access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	AST_SLVERR_QUAL: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside an access cycle");

	cover property ($rose(illegal_char_flag));
	cover property (pslverr);
	cover property ($rose(irq));
endmodule

bind decoder_error_detection decoder_error_detection_sva chk_u (.core_clk, .rst_n,
	.word_valid, .encoded_word, .word_done, .illegal_char_flag, .decode_start, .decode_done,
	.control_char_indication_upper, .control_char_indication_lower, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
`default_nettype wire

// >>> tb/decode_func_model.sv
// Behavioural model of the decode function that answers decode_start
`timescale 1ns/1ps
`default_nettype none
module decode_func_model (
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       decode_start, // Start strobe from the block
	input  wire logic [3:0] dly,          // Extra answer delay in cycles
	input  wire logic       k_u,          // Control flag to report, upper
	input  wire logic       k_l,          // Control flag to report, lower
	output logic            decode_done,  // One-cycle completion strobe
	output logic            k_up_out,     // Upper control indication
	output logic            k_lo_out      // Lower control indication
);
	logic [4:0] cnt_reg; // Cycles left before answering, 0 when idle

	// ----------------------------------------------------------------
	// Answer after the requested delay; indications toggle when not
	// valid so a block that samples them early sees garbage
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_reg     <= 5'h00;
			decode_done <= 1'b0;
			k_up_out    <= 1'b0;
			k_lo_out    <= 1'b0;
		end else if (decode_start) begin
			cnt_reg     <= {1'b0, dly} + 5'h01;
			decode_done <= 1'b0;
		end else if (cnt_reg == 5'h01) begin
			cnt_reg     <= 5'h00;
			decode_done <= 1'b1;
			k_up_out    <= k_u;
			k_lo_out    <= k_l;
		end else begin
			cnt_reg     <= (cnt_reg != 5'h00) ? cnt_reg - 5'h01 : cnt_reg;
			decode_done <= 1'b0;
			k_up_out    <= ~k_up_out;
			k_lo_out    <= ~k_lo_out;
		end
	end
endmodule
`default_nettype wire

// >>> tb/decoder_error_detection_bench.sv
// Self-checking bench for the decoder error detection block
`timescale 1ns/1ps
`default_nettype none
`include "decoder_error_detection_defs.svh"
module decoder_error_detection_bench;
	localparam logic [9:0] GOOD = 10'h2AA; // Five ones, legal for either disparity
	localparam logic [9:0] BAD  = 10'h000; // Run of zeros, always a violation
	logic        core_clk, rst_n, word_valid, word_done, illegal_char_flag, decode_start;
	logic        decode_done, k_up, k_lo, k_u, k_l, psel, penable, pwrite, pready;
	logic        pslverr, irq, done_q;
	logic [19:0] encoded_word;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  dly;
	logic        exp_flag_q[$], exp_err_q[$];
	logic [31:0] exp_rd_q[$];
	int          err_total, cmp_count, cycles, ill_n, words_n;

	decoder_error_detection dut_u (.core_clk(core_clk), .rst_n(rst_n),
		.word_valid(word_valid), .encoded_word(encoded_word), .word_done(word_done),
		.illegal_char_flag(illegal_char_flag), .decode_start(decode_start),
		.decode_done(decode_done), .control_char_indication_upper(k_up),
		.control_char_indication_lower(k_lo), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq));
	decode_func_model model_u (.core_clk(core_clk), .rst_n(rst_n),
		.decode_start(decode_start), .dly(dly), .k_u(k_u), .k_l(k_l),
		.decode_done(decode_done), .k_up_out(k_up), .k_lo_out(k_lo));

	// ----------------------------------------------------------------
	// Clock and result checking
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	task automatic chk_bit(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %b seen %b", nm, e, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wrap_up;
		if (exp_flag_q.size() != 0) err_total++; // A word never finished
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Watcher: takes the oldest note whenever a result appears
	always @(posedge core_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_err_q.size() != 0) chk_bit("pslverr", exp_err_q.pop_front(), pslverr);
			if (!pwrite && exp_rd_q.size() != 0) chk_word("prdata", exp_rd_q.pop_front(), prdata);
		end
		if (word_done === 1'b1 && !done_q && exp_flag_q.size() != 0)
			chk_bit("illegal_char_flag", exp_flag_q.pop_front(), illegal_char_flag);
		done_q = word_done;
		cycles++;
		if (cycles > 20000) begin // Hang guard
			err_total++;
			wrap_up();
		end
	end

	// ----------------------------------------------------------------
	// Drivers; apb ends one edge after release, send when word done is seen, so strobes never clash
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		if (!w) exp_rd_q.push_back(d); // For reads d is the expected data
		exp_err_q.push_back(e);
		psel <= 1'b1; pwrite <= w; paddr <= a; penable <= 1'b0;
		pwdata <= w ? d : 32'h0000_0000;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin @(posedge core_clk); end while (pready !== 1'b1);
		psel <= 1'b0; penable <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic send(input logic [9:0] up, lo, input logic ku, kl, input logic [3:0] d);
		logic e;
		e = ((up == BAD) && !ku) || ((lo == BAD) && !kl);
		exp_flag_q.push_back(e);
		ill_n += int'(e);
		words_n++;
		word_valid <= 1'b1; encoded_word <= {up, lo}; k_u <= ku; k_l <= kl; dly <= d;
		do begin @(posedge core_clk); end while (decode_start !== 1'b1);
		word_valid <= 1'b0;
		do begin @(posedge core_clk); end while (word_done !== 1'b1);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0; word_valid = 1'b0; encoded_word = 20'h0_0000; psel = 1'b0;
		penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0000_0000;
		k_u = 1'b0; k_l = 1'b0; dly = 4'h0; done_q = 1'b0;
		err_total = 0; cmp_count = 0; cycles = 0; ill_n = 0; words_n = 0;
		r = $urandom(32'hed69);
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		apb(1'b0, `DED_CTRL_OFFSET, 32'h0000_0003, 1'b0);
		apb(1'b0, `DED_IRQ_ENABLE_OFFSET, 32'h0000_0000, 1'b0);
		apb(1'b0, `DED_IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
		apb(1'b1, 8'h40, 32'hFFFF_FFFF, 1'b1);
		apb(1'b0, 8'h40, 32'h0000_0000, 1'b1);
		// Fixed words, then random back-to-back traffic with random delays
		send(GOOD, GOOD, 1'b0, 1'b0, 4'h0);
		send(GOOD, BAD, 1'b0, 1'b0, 4'h7);
		send(GOOD, BAD, 1'b0, 1'b1, 4'h3);
		send(BAD, GOOD, 1'b0, 1'b0, 4'h0);
		send(BAD, BAD, 1'b1, 1'b1, 4'h1);
		send(10'h3C1, 10'h3C1, 1'b0, 1'b0, 4'h2);
		send(10'h129, 10'h366, 1'b0, 1'b0, 4'h1);
		repeat (12) begin
			r = $urandom;
			send(r[0] ? BAD : GOOD, r[1] ? BAD : GOOD, r[2], r[3], r[7:4]);
		end
		apb(1'b0, `DED_WORD_COUNT_OFFSET, 32'(words_n), 1'b0);
		apb(1'b0, `DED_ILL_COUNT_OFFSET, 32'(ill_n), 1'b0);
		// Interrupt: raise, clear, masked done event, raise again
		apb(1'b1, `DED_IRQ_ENABLE_OFFSET, 32'h0000_0002, 1'b0);
		repeat (2) @(posedge core_clk);
		chk_bit("irq", 1'b1, irq);
		apb(1'b1, `DED_IRQ_CLEAR_OFFSET, 32'h0000_0007, 1'b0);
		repeat (2) @(posedge core_clk);
		chk_bit("irq", 1'b0, irq);
		apb(1'b0, `DED_IRQ_STATUS_OFFSET, 32'h0000_0000, 1'b0);
		send(GOOD, GOOD, 1'b0, 1'b0, 4'h2);
		repeat (3) @(posedge core_clk);
		chk_bit("irq", 1'b0, irq);
		apb(1'b0, `DED_IRQ_STATUS_OFFSET, 32'h0000_0001, 1'b0);
		send(GOOD, BAD, 1'b0, 1'b0, 4'h0);
		repeat (3) @(posedge core_clk);
		chk_bit("irq", 1'b1, irq);
		wrap_up();
	end
endmodule
`default_nettype wire
